// ---- fast_pcs_config_register.sv ----
// Fast PCS configuration register with strap loading and self-clearing seed load
`timescale 1ns/10ps
module fast_pcs_config_register #(
   parameter int NORMAL_CYC = pcs_cfg_pkg::TMO_NORMAL_CYC,
   parameter int BURST_CYC  = pcs_cfg_pkg::TMO_BURST_CYC
) (
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        reset_n,
   // Strap pins
   input  wire logic        strap_scrambler_bypass,
   input  wire logic        strap_block_code_bypass,
   input  wire logic        strap_symbol_alignment_bypass,
   // Management register port
   input  wire logic [4:0]  mgmt_addr,
   input  wire logic        mgmt_wr,
   input  wire logic [15:0] mgmt_wdata,
   input  wire logic        mgmt_rd,
   output logic [15:0]      mgmt_rdata_r,
   // Datapath status
   input  wire logic        seed_load_done,
   input  wire logic        tx_active,
   input  wire logic        link_monitor_good,
   input  wire logic        scr_activity,
   // Datapath controls
   output pcs_cfg_pkg::cfg_ctrl_t ctrl_r,
   output logic             seed_load_req_r,
   output logic             link_good_r,
   output logic             scr_timeout_r
);
   pcs_cfg_pkg::cfg_ctrl_t      ctrl_nxt;
   pcs_cfg_pkg::seed_state_t    seed_st_r;
   pcs_cfg_pkg::seed_state_t    seed_st_nxt;
   logic                        seed_req_nxt;
   logic                        link_good_nxt;
   logic [15:0]                 rdata_nxt;
   logic [15:0]                 image;
   logic                        wr_hit;
   logic                        seed_busy;

   // Bits the register defines; every other position is reserved
   localparam logic [15:0] USED_MASK = (16'h0001 << pcs_cfg_pkg::BIT_SCR_BP)
                                     | (16'h0001 << pcs_cfg_pkg::BIT_CODE_BP)
                                     | (16'h0001 << pcs_cfg_pkg::BIT_ALIGN_BP)
                                     | (16'h0001 << pcs_cfg_pkg::BIT_FORCE_LNK)
                                     | (16'h0001 << pcs_cfg_pkg::BIT_ACC_HALT)
                                     | (16'h0001 << pcs_cfg_pkg::BIT_SEED_LOAD)
                                     | (16'h0001 << pcs_cfg_pkg::BIT_BURST);

   assign wr_hit    = mgmt_wr && (mgmt_addr == pcs_cfg_pkg::CFG_REG_ADDR);
   assign seed_busy = (seed_st_r != pcs_cfg_pkg::SEED_IDLE);

   // Register image; unlisted bits stay zero
   always_comb begin
      image = '0;
      image[pcs_cfg_pkg::BIT_SCR_BP]    = ctrl_r.scr_bypass;
      image[pcs_cfg_pkg::BIT_CODE_BP]   = ctrl_r.code_bypass;
      image[pcs_cfg_pkg::BIT_ALIGN_BP]  = ctrl_r.align_bypass;
      image[pcs_cfg_pkg::BIT_FORCE_LNK] = ctrl_r.force_link;
      image[pcs_cfg_pkg::BIT_ACC_HALT]  = ctrl_r.accept_halt;
      image[pcs_cfg_pkg::BIT_SEED_LOAD] = seed_busy;
      image[pcs_cfg_pkg::BIT_BURST]     = ctrl_r.burst;
   end

   // Control bits
   always_comb begin
      ctrl_nxt = ctrl_r;
      if (wr_hit) begin
         ctrl_nxt.scr_bypass   = mgmt_wdata[pcs_cfg_pkg::BIT_SCR_BP];
         ctrl_nxt.code_bypass  = mgmt_wdata[pcs_cfg_pkg::BIT_CODE_BP];
         ctrl_nxt.align_bypass = mgmt_wdata[pcs_cfg_pkg::BIT_ALIGN_BP];
         ctrl_nxt.force_link   = mgmt_wdata[pcs_cfg_pkg::BIT_FORCE_LNK];
         ctrl_nxt.accept_halt  = mgmt_wdata[pcs_cfg_pkg::BIT_ACC_HALT];
         ctrl_nxt.burst        = mgmt_wdata[pcs_cfg_pkg::BIT_BURST];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         // Straps are sampled on every clock edge in reset, so the last one before release sticks
         ctrl_r              <= pcs_cfg_pkg::CTRL_RESET;
         ctrl_r.scr_bypass   <= strap_scrambler_bypass;
         ctrl_r.code_bypass  <= strap_block_code_bypass;
         ctrl_r.align_bypass <= strap_symbol_alignment_bypass;
      end else begin
         ctrl_r <= ctrl_nxt;
      end
   end

   // Seed load sequencer
   always_comb begin
      seed_st_nxt  = seed_st_r;
      seed_req_nxt = 1'b0;
      unique case (seed_st_r)
         pcs_cfg_pkg::SEED_IDLE: begin
            if (wr_hit && mgmt_wdata[pcs_cfg_pkg::BIT_SEED_LOAD]) begin
               seed_st_nxt  = pcs_cfg_pkg::SEED_LOADING;
               seed_req_nxt = 1'b1;
            end
         end
         pcs_cfg_pkg::SEED_LOADING: begin
            if (seed_load_done) begin
               seed_st_nxt = pcs_cfg_pkg::SEED_WAIT_TX;
            end
         end
         pcs_cfg_pkg::SEED_WAIT_TX: begin
            if (wr_hit && mgmt_wdata[pcs_cfg_pkg::BIT_SEED_LOAD]) begin
               // A fresh request beats the pending clear
               seed_st_nxt  = pcs_cfg_pkg::SEED_LOADING;
               seed_req_nxt = 1'b1;
            end else if (!tx_active) begin
               seed_st_nxt = pcs_cfg_pkg::SEED_IDLE;
            end
         end
         // The fourth code is never entered; fall back to idle if it is
         default: seed_st_nxt = pcs_cfg_pkg::SEED_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         seed_st_r       <= pcs_cfg_pkg::SEED_IDLE;
         seed_load_req_r <= 1'b0;
      end else begin
         seed_st_r       <= seed_st_nxt;
         seed_load_req_r <= seed_req_nxt;
      end
   end

   // Read data and link report
   always_comb begin
      rdata_nxt = pcs_cfg_pkg::RDATA_IDLE;
      if (mgmt_rd && (mgmt_addr == pcs_cfg_pkg::CFG_REG_ADDR)) begin
         rdata_nxt = image;
      end
      link_good_nxt = link_monitor_good || ctrl_r.force_link;
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         mgmt_rdata_r <= pcs_cfg_pkg::RDATA_IDLE;
         link_good_r  <= 1'b0;
      end else begin
         mgmt_rdata_r <= rdata_nxt;
         link_good_r  <= link_good_nxt;
      end
   end

   scr_timeout #(
      .NORMAL_CYC (NORMAL_CYC),
      .BURST_CYC  (BURST_CYC)
   ) u_timeout (
      .clk_sys   (clk_sys),
      .reset_n   (reset_n),
      .burst     (ctrl_r.burst),
      .activity  (scr_activity),
      .timeout_r (scr_timeout_r)
   );

   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   // Strap loading and reset values
   AST_STRAP_SCR: assert property (
      $rose(reset_n) |-> ctrl_r.scr_bypass == $past(strap_scrambler_bypass))
      else $error("scrambler bypass not loaded from strap");
   AST_STRAP_CODE: assert property (
      $rose(reset_n) |-> ctrl_r.code_bypass == $past(strap_block_code_bypass))
      else $error("block code bypass not loaded from strap");
   AST_STRAP_ALIGN: assert property (
      $rose(reset_n) |-> ctrl_r.align_bypass == $past(strap_symbol_alignment_bypass))
      else $error("alignment bypass not loaded from strap");
   AST_RESET_CTRL: assert property (
      $rose(reset_n) |-> !ctrl_r.force_link && !ctrl_r.accept_halt && !ctrl_r.burst
                         && !seed_busy && !seed_load_req_r
                         && mgmt_rdata_r == pcs_cfg_pkg::RDATA_IDLE)
      else $error("control not cleared by reset");

   // Field writes and link report
   AST_SCR_WRITE: assert property (
      wr_hit |=> ctrl_r.scr_bypass == $past(mgmt_wdata[pcs_cfg_pkg::BIT_SCR_BP]))
      else $error("scrambler bypass not written");
   AST_CODE_WRITE: assert property (
      wr_hit |=> ctrl_r.code_bypass == $past(mgmt_wdata[pcs_cfg_pkg::BIT_CODE_BP]))
      else $error("block code bypass not written");
   AST_ALIGN_WRITE: assert property (
      wr_hit |=> ctrl_r.align_bypass == $past(mgmt_wdata[pcs_cfg_pkg::BIT_ALIGN_BP]))
      else $error("alignment bypass not written");
   AST_FORCE_WRITE: assert property (
      wr_hit |=> ctrl_r.force_link == $past(mgmt_wdata[pcs_cfg_pkg::BIT_FORCE_LNK]))
      else $error("force link not written");
   AST_FORCE_LINK: assert property (
      ctrl_r.force_link |=> link_good_r)
      else $error("forced link not reported good");
   AST_LINK_FOLLOW: assert property (
      !ctrl_r.force_link |=> link_good_r == $past(link_monitor_good))
      else $error("link report does not follow monitor");
   AST_HALT_WRITE: assert property (
      wr_hit |=> ctrl_r.accept_halt == $past(mgmt_wdata[pcs_cfg_pkg::BIT_ACC_HALT]))
      else $error("accept halt not written");
   AST_BURST_WRITE: assert property (
      wr_hit |=> ctrl_r.burst == $past(mgmt_wdata[pcs_cfg_pkg::BIT_BURST]))
      else $error("burst bit not written");
   AST_WR_OTHER: assert property (
      mgmt_wr && mgmt_addr != pcs_cfg_pkg::CFG_REG_ADDR |=> $stable(ctrl_r))
      else $error("write to other address changed control");

   // Seed load handshake
   AST_SEED_REQ: assert property (
      wr_hit && mgmt_wdata[pcs_cfg_pkg::BIT_SEED_LOAD]
      && seed_st_r != pcs_cfg_pkg::SEED_LOADING |=> seed_load_req_r ##1 seed_busy)
      else $error("seed load not requested");
   AST_SEED_PULSE: assert property (
      seed_load_req_r |=> !seed_load_req_r)
      else $error("seed load request longer than one cycle");
   AST_SEED_ONLY_WR: assert property (
      !(wr_hit && mgmt_wdata[pcs_cfg_pkg::BIT_SEED_LOAD]) |=> !seed_load_req_r)
      else $error("seed load requested without a write");
   AST_SEED_WAIT_DONE: assert property (
      seed_st_r == pcs_cfg_pkg::SEED_LOADING && !seed_load_done
      |=> seed_st_r == pcs_cfg_pkg::SEED_LOADING)
      else $error("seed load left loading before done");
   AST_SEED_HOLD: assert property (
      seed_busy && tx_active && !wr_hit |=> seed_busy)
      else $error("seed load bit cleared during transmit");
   AST_SEED_CLEAR: assert property (
      seed_st_r == pcs_cfg_pkg::SEED_WAIT_TX && !tx_active
      && !(wr_hit && mgmt_wdata[pcs_cfg_pkg::BIT_SEED_LOAD]) |=> !seed_busy)
      else $error("seed load bit not cleared after load and transmit end");

   // Read port
   AST_SEED_READ: assert property (
      mgmt_rd && mgmt_addr == pcs_cfg_pkg::CFG_REG_ADDR && seed_busy
      |=> mgmt_rdata_r[pcs_cfg_pkg::BIT_SEED_LOAD])
      else $error("seed load bit read low while busy");
   AST_RD_OTHER: assert property (
      mgmt_rd && mgmt_addr != pcs_cfg_pkg::CFG_REG_ADDR
      |=> mgmt_rdata_r == pcs_cfg_pkg::RDATA_IDLE)
      else $error("read of other address not zero");
   AST_RSVD_ZERO: assert property (
      (mgmt_rdata_r & ~USED_MASK) == 16'h0000)
      else $error("reserved bit read nonzero");

   COV_SEED_DONE: cover property (seed_st_r == pcs_cfg_pkg::SEED_WAIT_TX ##1 !seed_busy);
   COV_SEED_WAIT: cover property (seed_st_r == pcs_cfg_pkg::SEED_WAIT_TX && tx_active);
   COV_SEED_IDLE_TX: cover property (seed_st_r == pcs_cfg_pkg::SEED_LOADING && !tx_active);
   COV_FORCE: cover property (ctrl_r.force_link && !link_monitor_good);
   COV_BURST_TMO: cover property (ctrl_r.burst && scr_timeout_r);
endmodule

// ---- pcs_cfg_pkg.sv ----
// Constants, field layout and carrier types of the fast PCS configuration register
// Overview of operation
// - Scrambler bypass 1 disables scrambler and descrambler; reset loads it from strap.
// - Block-code bypass 1 disables 4B/5B coder; reset loads it from strap.
// - Alignment bypass 1 passes unaligned receive data; reset loads it from strap.
// - Force-good-link 1 reports a good 100 Mbit/s link; resets to zero.
// - Accept-halt 1 forwards received halt symbols to MII; resets to zero.
// - Writing one to seed-load copies the user seed into the transmit scrambler.
// - Seed-load self-clears only after loading completes with no transmit; reads one meanwhile.
// - Burst mode stretches the scrambler time-out from 722 us to 2000 us.
package pcs_cfg_pkg;
   localparam logic [4:0]  CFG_REG_ADDR  = 5'h18;
   localparam int          BIT_SCR_BP    = 15;
   localparam int          BIT_CODE_BP   = 14;
   localparam int          BIT_ALIGN_BP  = 12;
   localparam int          BIT_FORCE_LNK = 9;
   localparam int          BIT_ACC_HALT  = 5;
   localparam int          BIT_SEED_LOAD = 4;
   localparam int          BIT_BURST     = 3;
   localparam logic [15:0] RDATA_IDLE    = 16'h0000;
   localparam int          CLK_MHZ       = 100;
   localparam int          TMO_NORMAL_US = 722;
   localparam int          TMO_BURST_US  = 2000;
   localparam int          TMO_NORMAL_CYC = TMO_NORMAL_US * CLK_MHZ;
   localparam int          TMO_BURST_CYC  = TMO_BURST_US * CLK_MHZ;
   localparam int          TMO_CNT_W     = 18;

   typedef struct packed {
      logic scr_bypass;
      logic code_bypass;
      logic align_bypass;
      logic force_link;
      logic accept_halt;
      logic burst;
   } cfg_ctrl_t;

   localparam cfg_ctrl_t CTRL_RESET = '{default: 1'b0};

   typedef enum logic [1:0] {SEED_IDLE, SEED_LOADING, SEED_WAIT_TX} seed_state_t;
endpackage

// ---- scr_timeout.sv ----
// Scrambler idle time-out timer with normal and burst periods
`timescale 1ns/10ps
module scr_timeout #(
   parameter int NORMAL_CYC = pcs_cfg_pkg::TMO_NORMAL_CYC,
   parameter int BURST_CYC  = pcs_cfg_pkg::TMO_BURST_CYC
) (
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic reset_n,
   // Control
   input  wire logic burst,
   input  wire logic activity,
   // Result
   output logic      timeout_r
);
   logic [pcs_cfg_pkg::TMO_CNT_W-1:0] cnt_r;
   logic [pcs_cfg_pkg::TMO_CNT_W-1:0] cnt_nxt;
   logic [pcs_cfg_pkg::TMO_CNT_W-1:0] limit;
   logic                              timeout_nxt;

   always_comb begin
      limit = burst ? BURST_CYC[pcs_cfg_pkg::TMO_CNT_W-1:0] - 1'b1
                    : NORMAL_CYC[pcs_cfg_pkg::TMO_CNT_W-1:0] - 1'b1;
      cnt_nxt     = cnt_r;
      timeout_nxt = 1'b0;
      if (activity) begin
         cnt_nxt = '0;
      end else if (cnt_r >= limit) begin
         // Switching burst off mid-count expires at once rather than wrapping
         cnt_nxt     = '0;
         timeout_nxt = 1'b1;
      end else begin
         cnt_nxt = cnt_r + 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         cnt_r     <= '0;
         timeout_r <= 1'b0;
      end else begin
         cnt_r     <= cnt_nxt;
         timeout_r <= timeout_nxt;
      end
   end
endmodule

// ---- seed_scrambler_model.sv ----
// Behavioural transmit scrambler that acknowledges seed loads after a delay
`timescale 1ns/10ps
module seed_scrambler_model #(
   parameter int DONE_DLY = 3
) (
   // Clock
   input  wire logic clk_sys,
   // Seed load handshake
   input  wire logic seed_load_req,
   output logic      seed_load_done
);
   int cnt = 0;

   initial seed_load_done = 1'b0;

   // Done is a single-cycle pulse, like a real loader finishing its copy
   always @(posedge clk_sys) begin
      #1;
      seed_load_done = (cnt == 1);
      if (seed_load_req === 1'b1)
         cnt = DONE_DLY;
      else if (cnt > 0)
         cnt = cnt - 1;
   end
endmodule

// ---- tb_fast_pcs_config_register.sv ----
// Testbench of the fast PCS configuration register
`timescale 1ns/10ps
module tb_fast_pcs_config_register;
   localparam int NCYC = 20;
   localparam int BCYC = 50;
   logic        clk_sys, reset_n, st_scr, st_code, st_align;
   logic [4:0]  mgmt_addr;
   logic        mgmt_wr, mgmt_rd, done, tx_active, mon_good, scr_activity;
   logic [15:0] mgmt_wdata, mgmt_rdata_r;
   pcs_cfg_pkg::cfg_ctrl_t ctrl_r;
   logic        seed_load_req_r, link_good_r, scr_timeout_r;
   int          miscompares = 0;
   int          n_checks = 0;
   int          gn, gb, ga;

   fast_pcs_config_register #(.NORMAL_CYC(NCYC), .BURST_CYC(BCYC)) dut (
      .clk_sys(clk_sys), .reset_n(reset_n), .strap_scrambler_bypass(st_scr),
      .strap_block_code_bypass(st_code), .strap_symbol_alignment_bypass(st_align),
      .mgmt_addr(mgmt_addr), .mgmt_wr(mgmt_wr), .mgmt_wdata(mgmt_wdata),
      .mgmt_rd(mgmt_rd), .mgmt_rdata_r(mgmt_rdata_r), .seed_load_done(done),
      .tx_active(tx_active), .link_monitor_good(mon_good), .scr_activity(scr_activity),
      .ctrl_r(ctrl_r), .seed_load_req_r(seed_load_req_r), .link_good_r(link_good_r),
      .scr_timeout_r(scr_timeout_r));

   seed_scrambler_model #(.DONE_DLY(3)) partner (
      .clk_sys(clk_sys), .seed_load_req(seed_load_req_r), .seed_load_done(done));

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic test_done;
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      mgmt_addr = a;
      mgmt_wdata = d;
      mgmt_wr = 1'b1;
      tick(1);
      mgmt_wr = 1'b0;
   endtask

   task automatic rd(input logic [4:0] a, input logic [15:0] exp);
      mgmt_addr = a;
      mgmt_rd = 1'b1;
      tick(1);
      mgmt_rd = 1'b0;
      chk(mgmt_rdata_r, exp, "read data");
   endtask

   // Gap between two consecutive time-out pulses, activity held off
   task automatic gap(output int g);
      int i;
      for (i = 0; i < 200 && scr_timeout_r !== 1'b1; i++)
         tick(1);
      g = 0;
      do begin
         tick(1);
         g++;
      end while (scr_timeout_r !== 1'b1 && g < 200);
      if (i == 200 || g == 200) begin
         miscompares++;
         $display("unexpected at %0t: no time-out pulse", $time);
         test_done();
      end
   endtask

   initial begin
      {mgmt_addr, mgmt_wr, mgmt_rd, mgmt_wdata} = '0;
      {tx_active, mon_good, scr_activity} = '0;
      {st_scr, st_code, st_align} = 3'b101;
      reset_n = 1'b0;
      tick(6);
      reset_n = 1'b1;
      rd(5'h18, 16'h9000);
      chk({10'h000, ctrl_r}, 16'h0028, "strap ctrl");
      // A second reset mid-run must pick up the new strap levels
      {st_scr, st_code, st_align} = 3'b010;
      reset_n = 1'b0;
      tick(2);
      reset_n = 1'b1;
      rd(5'h18, 16'h4000);
      $display("test straps done");
      wr(5'h18, 16'hFFEF);
      rd(5'h18, 16'hD228);
      chk({10'h000, ctrl_r}, 16'h003F, "all controls");
      chk({15'h0000, link_good_r}, 16'h0001, "forced link");
      wr(5'h17, 16'h0000);
      rd(5'h18, 16'hD228);
      tick(1);
      rd(5'h17, 16'h0000);
      wr(5'h18, 16'h0000);
      tick(1);
      chk({15'h0000, link_good_r}, 16'h0000, "link unforced");
      mon_good = 1'b1;
      tick(2);
      chk({15'h0000, link_good_r}, 16'h0001, "monitored link");
      mon_good = 1'b0;
      $display("test fields done");
      tx_active = 1'b1;
      wr(5'h18, 16'h0010);
      chk({15'h0000, seed_load_req_r}, 16'h0001, "seed request");
      tick(1);
      chk({15'h0000, seed_load_req_r}, 16'h0000, "seed request end");
      rd(5'h18, 16'h0010);
      tick(5);
      rd(5'h18, 16'h0010);
      tx_active = 1'b0;
      tick(2);
      rd(5'h18, 16'h0000);
      // With transmit idle the bit must still wait for the loader to finish
      wr(5'h18, 16'h0010);
      rd(5'h18, 16'h0010);
      tick(1);
      rd(5'h18, 16'h0010);
      tick(1);
      rd(5'h18, 16'h0010);
      tick(1);
      rd(5'h18, 16'h0000);
      $display("test seed load done");
      gap(gn);
      chk(16'(gn), 16'(NCYC), "normal time-out");
      wr(5'h18, 16'h0008);
      gap(gb);
      chk(16'(gb), 16'(BCYC), "burst time-out");
      chk(16'(gb - gn), 16'(BCYC - NCYC), "burst stretch");
      // Activity restarts the count, so the next pulse is a full period away
      scr_activity = 1'b1;
      tick(1);
      scr_activity = 1'b0;
      for (ga = 0; ga < 200 && scr_timeout_r !== 1'b1; ga++)
         tick(1);
      chk(16'(ga), 16'(BCYC), "restart by activity");
      $display("test burst done");
      test_done();
   end

   initial begin
      repeat (20000) @(posedge clk_sys);
      miscompares++;
      $display("unexpected at %0t: run limit reached", $time);
      test_done();
   end
endmodule
